// >>> hw/mpl_pkg.sv
package mpl_pkg;
   // clock and time base
   localparam int          MPL_CLK_HZ       = 125_000_000;
   localparam int          MPL_MS_PER_S     = 1000;
   localparam int          MPL_TICK_CYCLES  = MPL_CLK_HZ / MPL_MS_PER_S;
   localparam int          MPL_UNB_DELAY_S  = 5;
   localparam logic [15:0] MPL_UNB_DELAY_MS = 16'(MPL_UNB_DELAY_S * MPL_MS_PER_S);
   localparam logic [15:0] MPL_CHK_MS       = 16'h03e8;  // contactor feedback window
   localparam logic [15:0] MPL_COOL_MS_PER_S = 16'h000c; // 83 steps span the cooling time
   localparam int          MPL_COOL_SHIFT   = 4;         // each step removes 1/16
   // thresholds
   localparam logic [7:0]  MPL_UNB_ALM_PCT  = 8'h0f;     // 15 %
   localparam logic [7:0]  MPL_UNB_TRP_PCT  = 8'h1e;     // 30 %
   localparam logic [15:0] MPL_PU_ONE       = 16'h0100;  // 1.0 per unit of full load current
   localparam logic [6:0]  MPL_PCT_SCALE    = 7'h64;     // 100
   localparam logic [31:0] MPL_TCU_FULL     = 32'h0100_0000;
   localparam logic [31:0] MPL_TCU_RESET    = 32'h0026_6666; // 15 % of full
   localparam int          MPL_GAIN_SHIFT   = 16;
   localparam int          MPL_TCU_PCT_SHIFT = 24;
   // register word offsets (byte addresses)
   localparam logic [7:0] MPL_REG_CTRL   = 8'h00;
   localparam logic [7:0] MPL_REG_CMD    = 8'h04;
   localparam logic [7:0] MPL_REG_STALL  = 8'h08;
   localparam logic [7:0] MPL_REG_GF_ALM = 8'h0c;
   localparam logic [7:0] MPL_REG_GF_TRP = 8'h10;
   localparam logic [7:0] MPL_REG_THERM  = 8'h14;
   localparam logic [7:0] MPL_REG_UC_ALM = 8'h18;
   localparam logic [7:0] MPL_REG_UC_TRP = 8'h1c;
   localparam logic [7:0] MPL_REG_UP_ALM = 8'h20;
   localparam logic [7:0] MPL_REG_UP_TRP = 8'h24;
   localparam logic [7:0] MPL_REG_TIMES  = 8'h28;
   localparam logic [7:0] MPL_REG_BAUD   = 8'h2c;
   localparam logic [7:0] MPL_REG_AUX_EN = 8'h30;
   localparam logic [7:0] MPL_REG_STATUS = 8'h34;
   localparam logic [7:0] MPL_REG_ALARMS = 8'h38;
   localparam logic [7:0] MPL_REG_TRIPS  = 8'h3c;
   localparam logic [7:0] MPL_REG_TCU    = 8'h40;
   localparam logic [7:0] MPL_REG_RPT_CAUSE = 8'h44;
   localparam logic [7:0] MPL_REG_RPT_CUR   = 8'h48;
   localparam logic [7:0] MPL_REG_RPT_MISC  = 8'h4c;
   localparam logic [7:0] MPL_REG_RPT_TCU   = 8'h50;
   localparam int         MPL_WREG_N     = 13;           // words 0x00..0x30
   // control register fields
   localparam int MPL_CTRL_CURVE_LSB = 0;
   localparam int MPL_CTRL_START_LSB = 4;
   localparam int MPL_CTRL_GF_ZS     = 8;
   localparam int MPL_CTRL_THERM_NTC = 9;
   localparam int MPL_CTRL_STALL_OFF = 10;
   localparam int MPL_CTRL_REVERSE   = 11;
   localparam int MPL_CTRL_HIGH_SPD  = 12;
   localparam int MPL_CMD_START = 0;
   localparam int MPL_CMD_STOP  = 1;
   localparam int MPL_CMD_RESET = 2;
   localparam logic [31:0] MPL_CTRL_RESET = 32'h0000_0000;
   localparam int MPL_CURVE_N  = 12;
   localparam int MPL_BAUD_N   = 7;
   localparam int MPL_AUX_N    = 7;
   localparam int MPL_TMR_N    = 9;
   // heating gain per curve: 8 standard then 4 compatible curves
   localparam logic [15:0] MPL_CURVE_GAIN [MPL_CURVE_N] = '{
      16'h1000, 16'h0800, 16'h0555, 16'h0400, 16'h0333, 16'h02aa, 16'h0249, 16'h0200,
      16'h0cc0, 16'h0660, 16'h0440, 16'h0330};
   localparam int MPL_BAUD_RATE [MPL_BAUD_N] = '{1200, 2400, 4800, 9600, 19200, 38400, 57600};
   typedef enum logic [3:0] {
      MPL_ST_FVNR      = 4'h0,
      MPL_ST_REVERSING = 4'h1,
      MPL_ST_TWO_SPEED = 4'h2,
      MPL_ST_AUTOTX    = 4'h3,
      MPL_ST_INVERTER  = 4'h4,
      MPL_ST_WYE_OPEN  = 4'h5,
      MPL_ST_SLIP_RING = 4'h6,
      MPL_ST_PART_WIND = 4'h7,
      MPL_ST_WYE_CLOSE = 4'h8
   } mpl_starter_e;
   typedef struct packed {
      logic [15:0] i_max;   // largest phase rms, per unit q8.8
      logic [15:0] i_avg;   // average phase rms, per unit q8.8
      logic [7:0]  unb_pct;
      logic [15:0] gnd_res; // residual sum, per unit q8.8
      logic [15:0] gnd_zs;  // zero-sequence sensor, per unit q8.8
      logic [15:0] power_pct;
      logic [15:0] therm;
   } mpl_meter_s;
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } mpl_req_s;
endpackage

// >>> hw/mpl_top.sv
// Operation
// - overload trip when thermal capacity reaches 100%
// - thermal capacity accumulates squared current times curve
// - twelve selectable curves, eight standard, four compatible
// - unbalance over 15% for 5 s alarms
// - unbalance over 30% for 5 s trips
// - stall trip after current exceeds level for delay
// - stall function can be switched off
// - stall detection suppressed during starting inrush
// - ground current in percent, residual or zero-sequence
// - ground alarm and trip levels, each delayed
// - thermistor either polarity, alarm and trip levels
// - thermal capacity decays exponentially after trip
// - overload reset allowed only at 15% or below
// - stopped cooling rate derived from cooling time
// - undercurrent and underpower alarms and trips, delayed
// - check contactor after start and stop commands
// - programmable alarms for further abnormal conditions
// - starter type selects which contactor outputs drive
// - closed wye-delta drives both contactors plus auxiliary
// - every trip records cause and pre-trip metering
// - serial rate selectable 1200 to 57600 bps
// - start and stop from wired inputs or serial
`timescale 1ns/1ps
`default_nettype none
module mpl_top #(
   parameter int TICK_CYCLES = mpl_pkg::MPL_TICK_CYCLES
) (
   // clock and reset
   input  wire logic               sys_clk,
   input  wire logic               sys_rst,
   // register port
   input  wire mpl_pkg::mpl_req_s  bus_req,
   output logic [31:0]             bus_rdata,
   // metering from the analog front end
   input  wire mpl_pkg::mpl_meter_s meter,
   // switch and feedback pins
   input  wire logic               start_sw_pin,
   input  wire logic               stop_sw_pin,
   input  wire logic               contactor_closed_pin,
   input  wire logic [6:0]         aux_alarm_pin,
   // drive outputs
   output logic                    cont_a,
   output logic                    cont_b,
   output logic                    aux_out,
   output logic                    trip_out,
   output logic                    alarm_out,
   output logic [16:0]             baud_div
);
   import mpl_pkg::*;

   localparam int PIN_N = 3 + MPL_AUX_N;
   localparam int TW    = $clog2(TICK_CYCLES + 1);

   // refuse a time base shorter than two clock cycles
   generate
      if (TICK_CYCLES < 2)
      begin : g_bad_tick
         $error("TICK_CYCLES must be at least 2");
      end
   endgenerate

   // pin synchronisers and edge history
   logic [PIN_N-1:0] pin_s1;
   logic [PIN_N-1:0] pin_s2;
   logic [PIN_N-1:0] pin_s3;
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         pin_s1 <= '0;
         pin_s2 <= '0;
         pin_s3 <= '0;
      end
      else
      begin
         pin_s1 <= {aux_alarm_pin, contactor_closed_pin, stop_sw_pin, start_sw_pin};
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
      end
   end

   // state
   logic [31:0]       wreg [MPL_WREG_N];
   logic [TW-1:0]     tick_cnt;
   logic              tick;
   logic              running;
   logic [6:0]        trips;
   logic [14:0]       alarms;
   logic [31:0]       tcu;
   logic [15:0]       cool_cnt;
   logic [15:0]       chk_cnt;
   logic              chk_close;
   logic [15:0]       inrush_cnt;
   logic              inrush;
   logic              closed_d;
   logic [31:0]       rpt_cause;
   logic [31:0]       rpt_cur;
   logic [31:0]       rpt_misc;
   logic [31:0]       rpt_tcu;
   logic [31:0]       next_wreg [MPL_WREG_N];
   logic [TW-1:0]     next_tick_cnt;
   logic              next_tick;
   logic              next_running;
   logic [6:0]        next_trips;
   logic [14:0]       next_alarms;
   logic [31:0]       next_tcu;
   logic [15:0]       next_cool_cnt;
   logic [15:0]       next_chk_cnt;
   logic              next_chk_close;
   logic [15:0]       next_inrush_cnt;
   logic              next_inrush;
   logic [31:0]       next_rpt_cause;
   logic [31:0]       next_rpt_cur;
   logic [31:0]       next_rpt_misc;
   logic [31:0]       next_rpt_tcu;
   logic [31:0]       next_rdata;
   logic              next_cont_a;
   logic              next_cont_b;
   logic              next_aux_out;
   logic [16:0]       next_baud_div;

   // decoded configuration
   logic [3:0]        curve;
   mpl_starter_e      starter;
   logic              wr_cmd;
   logic              cmd_start;
   logic              cmd_stop;
   logic              cmd_reset;
   logic              closed;
   logic [15:0]       i_pct;
   logic [15:0]       iavg_pct;
   logic [15:0]       gnd_pct;
   logic [15:0]       gnd_sel;
   logic [31:0]       i_sq;
   logic [47:0]       heat;
   logic [39:0]       tcu_pct_w;
   logic [7:0]        tcu_pct;
   logic              therm_alm;
   logic              therm_trp;
   logic [15:0]       cool_step;
   logic [2:0]        baud_sel;
   logic [MPL_TMR_N-1:0] tmr_cond;
   logic [MPL_TMR_N-1:0] tmr_fire;
   logic [15:0]       tmr_dly [MPL_TMR_N];

   assign curve    = wreg[0][MPL_CTRL_CURVE_LSB +: 4];
   assign starter  = mpl_starter_e'(wreg[0][MPL_CTRL_START_LSB +: 4]);
   assign closed   = pin_s2[2];
   assign baud_sel = wreg[11][2:0];
   // serial and wired commands share one path
   assign wr_cmd    = bus_req.wr && (bus_req.addr == MPL_REG_CMD);
   assign cmd_start = (wr_cmd && bus_req.wdata[MPL_CMD_START]) || (pin_s2[0] && !pin_s3[0]);
   assign cmd_stop  = (wr_cmd && bus_req.wdata[MPL_CMD_STOP]) || (pin_s2[1] && !pin_s3[1]);
   assign cmd_reset = wr_cmd && bus_req.wdata[MPL_CMD_RESET];

   // measured values as percent of full load current
   assign gnd_sel  = wreg[0][MPL_CTRL_GF_ZS] ? meter.gnd_zs : meter.gnd_res;
   assign gnd_pct  = 16'((24'(gnd_sel) * 24'(MPL_PCT_SCALE)) >> 8);
   assign i_pct    = 16'((24'(meter.i_max) * 24'(MPL_PCT_SCALE)) >> 8);
   assign iavg_pct = 16'((24'(meter.i_avg) * 24'(MPL_PCT_SCALE)) >> 8);
   // squared current scaled by the selected curve
   assign i_sq     = 32'(meter.i_max) * 32'(meter.i_max);
   assign heat     = (48'(i_sq) * 48'(MPL_CURVE_GAIN[(curve < 4'(MPL_CURVE_N)) ? curve : 4'h0]))
                     >> MPL_GAIN_SHIFT;
   assign tcu_pct_w = (40'(tcu) * 40'(MPL_PCT_SCALE)) >> MPL_TCU_PCT_SHIFT;
   assign tcu_pct   = (tcu_pct_w > 40'(MPL_PCT_SCALE)) ? 8'(MPL_PCT_SCALE) : tcu_pct_w[7:0];
   // thermistor polarity flips the compare
   assign therm_alm = wreg[0][MPL_CTRL_THERM_NTC] ? (meter.therm < wreg[5][15:0])
                                                  : (meter.therm > wreg[5][15:0]);
   assign therm_trp = wreg[0][MPL_CTRL_THERM_NTC] ? (meter.therm < wreg[5][31:16])
                                                  : (meter.therm > wreg[5][31:16]);
   assign cool_step = 16'(wreg[10][15:0] * MPL_COOL_MS_PER_S);

   // timer conditions and delays
   always_comb
   begin
      tmr_cond[0] = meter.unb_pct > MPL_UNB_ALM_PCT;
      tmr_cond[1] = meter.unb_pct > MPL_UNB_TRP_PCT;
      tmr_cond[2] = running && !inrush && !wreg[0][MPL_CTRL_STALL_OFF]
                    && (i_pct > wreg[2][15:0]);
      tmr_cond[3] = gnd_pct > wreg[3][15:0];
      tmr_cond[4] = gnd_pct > wreg[4][15:0];
      tmr_cond[5] = running && !inrush && (iavg_pct < wreg[6][15:0]);
      tmr_cond[6] = running && !inrush && (iavg_pct < wreg[7][15:0]);
      tmr_cond[7] = running && !inrush && (meter.power_pct < wreg[8][15:0]);
      tmr_cond[8] = running && !inrush && (meter.power_pct < wreg[9][15:0]);
      tmr_dly[0]  = MPL_UNB_DELAY_MS;
      tmr_dly[1]  = MPL_UNB_DELAY_MS;
      // undercurrent and underpower words sit above the thermistor word
      for (int k = 2; k < MPL_TMR_N; k++)
      begin
         tmr_dly[k] = wreg[(k < 5) ? k : k + 1][31:16];
      end
   end

   // delay timers counting milliseconds
   generate
      for (genvar g = 0; g < MPL_TMR_N; g++)
      begin : g_tmr
         logic [15:0] cnt;
         logic [15:0] next_cnt;
         always_comb
         begin
            next_cnt = cnt;
            if (!tmr_cond[g])
               next_cnt = '0;
            else if (tick && (cnt <= tmr_dly[g]))
               next_cnt = cnt + 16'h0001;
         end
         assign tmr_fire[g] = tmr_cond[g] && (cnt > tmr_dly[g]);
         always_ff @(posedge sys_clk)
         begin
            if (sys_rst)
               cnt <= '0;
            else
               cnt <= next_cnt;
         end
      end
   endgenerate

   // control, protection and register next state
   always_comb
   begin
      logic [6:0]  trip_set;
      logic [14:0] alarm_set;
      logic [6:0]  trip_clr;
      trip_set  = '0;
      alarm_set = '0;
      trip_clr  = '0;
      for (int k = 0; k < MPL_WREG_N; k++)
      begin
         next_wreg[k] = wreg[k];
      end
      if (bus_req.wr && (bus_req.addr[7:2] < 6'(MPL_WREG_N)) && !wr_cmd)
         next_wreg[bus_req.addr[5:2]] = bus_req.wdata;
      // millisecond tick
      next_tick     = 1'b0;
      next_tick_cnt = tick_cnt + TW'(1);
      if (tick_cnt == TW'(TICK_CYCLES - 1))
      begin
         next_tick_cnt = '0;
         next_tick     = 1'b1;
      end
      // thermal model
      next_tcu      = tcu;
      next_cool_cnt = cool_cnt;
      if (tick)
      begin
         if (running && (meter.i_max > MPL_PU_ONE))
         begin
            next_tcu      = (tcu + heat[31:0] > MPL_TCU_FULL) ? MPL_TCU_FULL
                                                              : tcu + heat[31:0];
            next_cool_cnt = '0;
         end
         else if ((cool_cnt + 16'h0001) >= cool_step) // decay on the last ms of the step
         begin
            next_tcu      = tcu - (tcu >> MPL_COOL_SHIFT);
            next_cool_cnt = '0;
         end
         else
            next_cool_cnt = cool_cnt + 16'h0001;
      end
      // trip and alarm sources
      trip_set[0]  = tcu >= MPL_TCU_FULL;
      trip_set[1]  = tmr_fire[1];
      trip_set[2]  = tmr_fire[2];
      trip_set[3]  = tmr_fire[4];
      trip_set[4]  = therm_trp;
      trip_set[5]  = tmr_fire[6];
      trip_set[6]  = tmr_fire[8];
      alarm_set[0] = tmr_fire[0];
      alarm_set[1] = tmr_fire[3];
      alarm_set[2] = therm_alm;
      alarm_set[3] = tmr_fire[5];
      alarm_set[4] = tmr_fire[7];
      alarm_set[14:8] = pin_s2[PIN_N-1:3] & wreg[12][MPL_AUX_N-1:0];
      // contactor feedback check
      next_chk_cnt   = chk_cnt;
      next_chk_close = chk_close;
      if (cmd_stop || (|trip_set))
      begin
         next_chk_cnt   = MPL_CHK_MS;
         next_chk_close = 1'b0;
      end
      else if (cmd_start && !running && (trips == '0))
      begin
         next_chk_cnt   = MPL_CHK_MS;
         next_chk_close = 1'b1;
      end
      else if (tick && (chk_cnt != '0))
         next_chk_cnt = chk_cnt - 16'h0001;
      if (tick && (chk_cnt == 16'h0001))
      begin
         alarm_set[5] = chk_close && !closed;
         alarm_set[6] = !chk_close && closed;
      end
      // starting inrush window and acceleration alarm
      next_inrush     = inrush;
      next_inrush_cnt = inrush_cnt;
      if (!running)
         next_inrush = 1'b0;
      else if (closed && !closed_d)
      begin
         next_inrush     = 1'b1;
         next_inrush_cnt = wreg[10][31:16];
      end
      else if (inrush && tick)
      begin
         if (inrush_cnt == '0)
         begin
            next_inrush  = 1'b0;
            alarm_set[7] = meter.i_max > MPL_PU_ONE;
         end
         else
            next_inrush_cnt = inrush_cnt - 16'h0001;
      end
      // reset clears trips; overload waits for cooling
      if (cmd_reset)
      begin
         trip_clr       = 7'h7e;
         trip_clr[0]    = tcu <= MPL_TCU_RESET;
      end
      next_trips  = (trips & ~trip_clr) | trip_set;
      next_alarms = (cmd_reset ? 15'h0000 : alarms) | alarm_set;
      // run state
      next_running = running;
      if (cmd_stop || (|trip_set) || (trips != '0))
         next_running = 1'b0;
      else if (cmd_start)
         next_running = 1'b1;
      // trip report on each new trip
      next_rpt_cause = rpt_cause;
      next_rpt_cur   = rpt_cur;
      next_rpt_misc  = rpt_misc;
      next_rpt_tcu   = rpt_tcu;
      if (|(trip_set & ~trips))
      begin
         next_rpt_cause = {25'h0, trip_set & ~trips};
         next_rpt_cur   = {meter.i_max, gnd_pct};
         next_rpt_misc  = {8'h00, meter.unb_pct, meter.power_pct};
         next_rpt_tcu   = {24'h0, tcu_pct};
      end
      // contactor outputs by starter type
      next_cont_a  = 1'b0;
      next_cont_b  = 1'b0;
      next_aux_out = 1'b0;
      case (starter)
         MPL_ST_FVNR:
            next_cont_a = next_running;
         MPL_ST_REVERSING:
         begin
            next_cont_a = next_running && !wreg[0][MPL_CTRL_REVERSE];
            next_cont_b = next_running && wreg[0][MPL_CTRL_REVERSE];
         end
         MPL_ST_TWO_SPEED:
         begin
            next_cont_a = next_running && !wreg[0][MPL_CTRL_HIGH_SPD];
            next_cont_b = next_running && wreg[0][MPL_CTRL_HIGH_SPD];
         end
         MPL_ST_AUTOTX, MPL_ST_INVERTER, MPL_ST_WYE_OPEN, MPL_ST_SLIP_RING, MPL_ST_PART_WIND:
         begin
            next_cont_a = next_running;
            next_cont_b = next_running && running && !inrush && closed_d;
         end
         MPL_ST_WYE_CLOSE:
         begin
            next_cont_a  = next_running;
            next_cont_b  = next_running && running && !inrush && closed_d;
            next_aux_out = next_running && (inrush || !closed_d);
         end
         default:
            next_cont_a = 1'b0;
      endcase
      // serial rate divider
      next_baud_div = 17'(MPL_CLK_HZ / MPL_BAUD_RATE[0]);
      for (int k = 0; k < MPL_BAUD_N; k++)
      begin
         if (baud_sel == 3'(k))
            next_baud_div = 17'(MPL_CLK_HZ / MPL_BAUD_RATE[k]);
      end
      // register read data
      next_rdata = 32'h0000_0000;
      if (bus_req.rd)
      begin
         if ((bus_req.addr[7:2] < 6'(MPL_WREG_N)) && (bus_req.addr != MPL_REG_CMD)
             && (bus_req.addr[1:0] == 2'b00))
            next_rdata = wreg[bus_req.addr[5:2]];
         else
            case (bus_req.addr)
               MPL_REG_STATUS:    next_rdata = {27'h0, closed, inrush, |alarms, |trips, running};
               MPL_REG_ALARMS:    next_rdata = {17'h0, alarms};
               MPL_REG_TRIPS:     next_rdata = {25'h0, trips};
               MPL_REG_TCU:       next_rdata = {24'h0, tcu_pct};
               MPL_REG_RPT_CAUSE: next_rdata = rpt_cause;
               MPL_REG_RPT_CUR:   next_rdata = rpt_cur;
               MPL_REG_RPT_MISC:  next_rdata = rpt_misc;
               MPL_REG_RPT_TCU:   next_rdata = rpt_tcu;
               default:           next_rdata = 32'h0000_0000;
            endcase
      end
   end

   // register all control state
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         for (int k = 0; k < MPL_WREG_N; k++)
            wreg[k] <= MPL_CTRL_RESET;
         tick_cnt   <= '0;
         tick       <= 1'b0;
         running    <= 1'b0;
         trips      <= '0;
         alarms     <= '0;
         tcu        <= '0;
         cool_cnt   <= '0;
         chk_cnt    <= '0;
         chk_close  <= 1'b0;
         inrush_cnt <= '0;
         inrush     <= 1'b0;
         closed_d   <= 1'b0;
         rpt_cause  <= '0;
         rpt_cur    <= '0;
         rpt_misc   <= '0;
         rpt_tcu    <= '0;
         bus_rdata  <= '0;
         cont_a     <= 1'b0;
         cont_b     <= 1'b0;
         aux_out    <= 1'b0;
         trip_out   <= 1'b0;
         alarm_out  <= 1'b0;
         baud_div   <= '0;
      end
      else
      begin
         for (int k = 0; k < MPL_WREG_N; k++)
            wreg[k] <= next_wreg[k];
         tick_cnt   <= next_tick_cnt;
         tick       <= next_tick;
         running    <= next_running;
         trips      <= next_trips;
         alarms     <= next_alarms;
         tcu        <= next_tcu;
         cool_cnt   <= next_cool_cnt;
         chk_cnt    <= next_chk_cnt;
         chk_close  <= next_chk_close;
         inrush_cnt <= next_inrush_cnt;
         inrush     <= next_inrush;
         closed_d   <= closed;
         rpt_cause  <= next_rpt_cause;
         rpt_cur    <= next_rpt_cur;
         rpt_misc   <= next_rpt_misc;
         rpt_tcu    <= next_rpt_tcu;
         bus_rdata  <= next_rdata;
         cont_a     <= next_cont_a;
         cont_b     <= next_cont_b;
         aux_out    <= next_aux_out;
         trip_out   <= next_trips != '0;
         alarm_out  <= next_alarms != '0;
         baud_div   <= next_baud_div;
      end
   end
endmodule
`default_nettype wire

// >>> verification/mpl_contactor_model.sv
`timescale 1ns/1ps
`default_nettype none
module mpl_contactor_model (
   // coil drive and fault control
   input  wire logic sys_clk,
   input  wire logic coil,
   input  wire logic welded,
   // auxiliary feedback contact
   output logic      closed
);
   logic [3:0] travel = 4'h0;
   logic       held   = 1'b0;
   // armature lags the coil; a welded tip never opens again
   always @(posedge sys_clk)
   begin
      travel <= {travel[2:0], coil};
      held   <= welded ? held : travel[3];
   end
   assign closed = held;
endmodule
`default_nettype wire

// >>> verification/mpl_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module mpl_top_asserts #(
   parameter int TICK_CYCLES = 2
) (
   // clock and reset
   input wire logic              sys_clk,
   input wire logic              sys_rst,
   // register port and drives
   input wire mpl_pkg::mpl_req_s bus_req,
   input wire logic [31:0]       bus_rdata,
   input wire logic              cont_a,
   input wire logic              trip_out,
   input wire logic              alarm_out,
   input wire logic [16:0]       baud_div
);
   import mpl_pkg::*;
   logic cmd, clr;
   // decoded command writes
   assign cmd = bus_req.wr && bus_req.addr == MPL_REG_CMD;
   assign clr = cmd && bus_req.wdata[MPL_CMD_RESET];
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   sequence s_start;
      cmd && bus_req.wdata[2:0] == 3'h1 && !trip_out && !cont_a;
   endsequence
   sequence s_stop;
      cmd && bus_req.wdata[2:0] == 3'h2 && cont_a;
   endsequence
   chk_start_drive: assert property (s_start |-> ##2 cont_a)
      else $error("start did not energise contactor");
   chk_stop_drive: assert property (s_stop |-> ##2 !cont_a)
      else $error("stop did not open contactor");
   chk_trip_opens: assert property ($rose(trip_out) |-> ##[0:3] !cont_a)
      else $error("trip left contactor energised");
   chk_trip_hold: assert property (trip_out && !clr && !$past(clr) |=> trip_out)
      else $error("trip cleared without reset");
   chk_alarm_hold: assert property (alarm_out && !clr && !$past(clr) |=> alarm_out)
      else $error("alarm cleared without reset");
   chk_baud_legal: assert property (!$past(sys_rst) |-> baud_div inside
      {17'h196e6, 17'h0cb73, 17'h065b9, 17'h032dc, 17'h0196e, 17'h00cb7, 17'h0087a})
      else $error("serial divisor out of range");
   chk_rdata_idle: assert property (!bus_req.rd |=> bus_rdata == 32'h0)
      else $error("read data without read");
   chk_cmd_reads: assert property (bus_req.rd && bus_req.addr == MPL_REG_CMD |=> bus_rdata == 32'h0)
      else $error("command word read back");
endmodule
bind mpl_top mpl_top_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.sys_clk(sys_clk),
   .sys_rst(sys_rst), .bus_req(bus_req), .bus_rdata(bus_rdata), .cont_a(cont_a),
   .trip_out(trip_out), .alarm_out(alarm_out), .baud_div(baud_div));
`default_nettype wire

// >>> verification/mpl_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module mpl_top_tb;
   import mpl_pkg::*;
   localparam int TICK = 2;
   logic        sys_clk  = 1'b0;
   logic        sys_rst  = 1'b1;
   mpl_req_s    req      = '0;
   mpl_meter_s  meter    = '0;
   logic        start_sw = 1'b0;
   logic        weld     = 1'b0;
   logic        stop_sw  = 1'b0;
   logic [6:0]  aux      = 7'h00;
   logic [31:0] rdata;
   logic [16:0] baud;
   logic        closed, cont_a, cont_b, trip, aux_o, alarm;
   int          n_fail, n_compared, cyc;
   // block under test and its contactor
   mpl_top #(.TICK_CYCLES(TICK)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus_req(req),
      .bus_rdata(rdata), .meter(meter), .start_sw_pin(start_sw), .stop_sw_pin(stop_sw),
      .contactor_closed_pin(closed), .aux_alarm_pin(aux), .cont_a(cont_a), .cont_b(cont_b),
      .aux_out(aux_o), .trip_out(trip), .alarm_out(alarm), .baud_div(baud));
   mpl_contactor_model u_cont (.sys_clk(sys_clk), .coil(cont_a), .welded(weld), .closed(closed));
   // clock and hang guard
   always #4 sys_clk = ~sys_clk;
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         n_fail++;
         conclude();
      end
   end
   task automatic conclude();
      $display("compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      n_compared++;
      if (seen !== want)
      begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, want);
      end
   endtask
   task automatic ms(input int n);
      repeat (n * TICK) @(posedge sys_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      req <= '{a, d, 1'b1, 1'b0};
      @(posedge sys_clk);
      req <= '0;
   endtask
   // read one word, compare the masked bits, return on an edge
   task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      @(posedge sys_clk);
      req <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge sys_clk);
      req <= '0;
      #1 check(rdata & m, e);
      @(posedge sys_clk);
   endtask
   // main sequence
   initial
   begin
      repeat (10) @(posedge sys_clk);
      sys_rst <= 1'b0;
      rc(MPL_REG_CTRL, 32'hffff_ffff, 32'h0);
      rc(8'hfc, 32'hffff_ffff, 32'h0);
      for (int k = 0; k < 8; k++)
      begin
         wr(MPL_REG_BAUD, k);
         repeat (2) @(posedge sys_clk);
         check(baud, MPL_CLK_HZ / MPL_BAUD_RATE[k % 7]);
      end
      wr(MPL_REG_CTRL, 32'h0000_0400);
      wr(MPL_REG_TIMES, 32'h0000_0001);
      wr(MPL_REG_CMD, 32'h0000_0001);
      repeat (8) @(posedge sys_clk);
      check({cont_a, cont_b, aux_o}, 3'b100);
      rc(MPL_REG_STATUS, 32'h11, 32'h11);
      meter.unb_pct <= MPL_UNB_ALM_PCT;
      ms(5100);
      rc(MPL_REG_ALARMS, 32'h1, 32'h0);
      // two interrupted excursions must not add up
      for (int k = 0; k < 2; k++)
      begin
         meter.unb_pct <= MPL_UNB_ALM_PCT + 8'h01;
         ms(4000);
         meter.unb_pct <= 8'h00;
         ms(1);
      end
      rc(MPL_REG_ALARMS, 32'h1, 32'h0);
      meter.unb_pct <= MPL_UNB_ALM_PCT + 8'h01;
      ms(5100);
      rc(MPL_REG_ALARMS, 32'h1, 32'h1);
      meter.unb_pct <= 8'h00;
      // twice full load fills the thermal model in 1024 ms
      meter.i_max <= 16'h0200;
      ms(1000);
      rc(MPL_REG_TRIPS, 32'h1, 32'h0);
      ms(30);
      rc(MPL_REG_TRIPS, 32'h5, 32'h1);
      check({trip, cont_a}, 2'b10);
      rc(MPL_REG_TCU, 32'hff, 32'h64);
      rc(MPL_REG_RPT_CAUSE, 32'hff, 32'h1);
      rc(MPL_REG_RPT_CUR, 32'hffff_0000, 32'h0200_0000);
      meter.i_max <= 16'h0000;
      ms(300);
      wr(MPL_REG_CMD, 32'h4);
      rc(MPL_REG_TRIPS, 32'h1, 32'h1);
      ms(100);
      wr(MPL_REG_CMD, 32'h4);
      rc(MPL_REG_TRIPS, 32'h1, 32'h0);
      // wired start, then a stop against a welded tip
      start_sw <= 1'b1;
      repeat (12) @(posedge sys_clk);
      check(cont_a, 1'b1);
      weld <= 1'b1;
      wr(MPL_REG_CMD, 32'h2);
      ms(1010);
      rc(MPL_REG_ALARMS, 32'h60, 32'h40);
      check(alarm, 1'b1);
      // serial start, wired stop, and an enabled external alarm
      wr(MPL_REG_AUX_EN, 32'h0000_0001);
      aux <= 7'h01;
      wr(MPL_REG_CMD, 32'h0000_0001);
      stop_sw <= 1'b1;
      repeat (6) @(posedge sys_clk);
      check(cont_a, 1'b0);
      rc(MPL_REG_ALARMS, 32'h100, 32'h100);
      conclude();
   end
endmodule
`default_nettype wire
